// *** upc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module upc_ctrl #(
  parameter int SHORT_PULSE_CYCLES = upc_pkg::SHORT_PULSE_CYC,
  parameter int PRIME_PULSE_CYCLES = upc_pkg::PRIME_PULSE_CYC,
  parameter int SETUP_CYCLES = upc_pkg::SETUP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire upc_pkg::upc_req_t req,
  output logic rsp_valid,
  output upc_pkg::upc_rsp_t rsp,
  output upc_pkg::upc_pins_t pins,
  input wire logic [upc_pkg::DATA_W-1:0] data_pins_in
);
  import upc_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_SETUP = 7'h02,
    S_PULSE = 7'h04,
    S_REL = 7'h08,
    S_VERIFY = 7'h10,
    S_FINAL = 7'h20,
    S_DONE = 7'h40
  } upc_state_t;

  upc_state_t state_r, state_nxt;
  upc_req_t req_r, req_nxt;
  upc_pins_t pins_r, pins_nxt;
  upc_rsp_t rsp_r, rsp_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [4:0] x_r, x_nxt;
  logic final_r, final_nxt;
  logic [DATA_W-1:0] din_s1_r, din_s2_r;

  function automatic logic is_prog(input upc_cmd_t c);
    return (c == UPC_CMD_PROG_SHORT) || (c == UPC_CMD_PROG_FAST);
  endfunction

  assign req_ready = (state_r == S_IDLE);
  assign rsp_valid = (state_r == S_DONE);
  assign pins = pins_r;
  assign rsp = rsp_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end else if (clk_en) begin
      din_s1_r <= data_pins_in;
      din_s2_r <= din_s1_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    pins_nxt = pins_r;
    rsp_nxt = rsp_r;
    cnt_nxt = cnt_r;
    x_nxt = x_r;
    final_nxt = final_r;
    unique case (state_r)
      S_IDLE: begin
        if (req_valid) begin
          req_nxt = req;
          x_nxt = 5'h00;
          final_nxt = 1'b0;
          cnt_nxt = 32'(SETUP_CYCLES);
          rsp_nxt = '0;
          // any address order accepted
          pins_nxt.address_inputs = req.addr;
          pins_nxt.id_unlock_hv = 1'b0;
          if (req.cmd == UPC_CMD_ID) begin
            // only the byte-select bit may be high
            pins_nxt.address_inputs = req.addr & ID_BYTE_BIT;
            pins_nxt.id_unlock_hv = 1'b1;
          end
          if (is_prog(req.cmd)) begin
            pins_nxt.prog_hv = 1'b1;
            pins_nxt.out_en_n = 1'b1;
            pins_nxt.data_out = req.data;
            pins_nxt.data_oe_n = 1'b0;
            pins_nxt.chip_sel_n = 1'b1;
          end else begin
            pins_nxt.data_oe_n = 1'b1;
            pins_nxt.chip_sel_n = 1'b0;
            pins_nxt.out_en_n = 1'b0;
            cnt_nxt = 32'(READ_WAIT_CYC);
          end
          state_nxt = is_prog(req.cmd) ? S_SETUP : S_VERIFY;
        end
      end
      S_SETUP: begin
        if (cnt_r <= 32'd1) begin
          // select pulsed only after address and data settled
          pins_nxt.chip_sel_n = 1'b0;
          if (final_r) begin
            cnt_nxt = 32'(PRIME_PULSE_CYCLES) *
              32'(FINAL_MULT) * 32'(x_r);
            state_nxt = S_FINAL;
          end else begin
            if (req_r.cmd == UPC_CMD_PROG_SHORT) begin
              cnt_nxt = 32'(SHORT_PULSE_CYCLES);
            end else begin
              cnt_nxt = 32'(PRIME_PULSE_CYCLES);
            end
            x_nxt = x_r + 5'h01;
            state_nxt = S_PULSE;
          end
        end else begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      S_PULSE: begin
        // address and data held for the full pulse
        if (cnt_r <= 32'd1) begin
          pins_nxt.chip_sel_n = 1'b1;
          cnt_nxt = 32'(SETUP_CYCLES);
          state_nxt = S_REL;
        end else begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      S_REL: begin
        if (cnt_r <= 32'd1) begin
          if (final_r) begin
            state_nxt = S_DONE;
            pins_nxt.data_oe_n = 1'b1;
            pins_nxt.prog_hv = 1'b0;
          end else begin
            // drop bus in the same cycle the verify read enables select and outputs
            pins_nxt.data_oe_n = 1'b1;
            pins_nxt.prog_hv = 1'b0;
            pins_nxt.out_en_n = 1'b0;
            pins_nxt.chip_sel_n = 1'b0;
            cnt_nxt = 32'(READ_WAIT_CYC);
            state_nxt = S_VERIFY;
          end
        end else begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      S_VERIFY: begin
        if (cnt_r <= 32'd1) begin
          rsp_nxt.data = din_s2_r;
          rsp_nxt.pulses = x_r;
          rsp_nxt.parity_ok = ^din_s2_r;
          pins_nxt.out_en_n = 1'b1;
          pins_nxt.chip_sel_n = 1'b1;
          pins_nxt.id_unlock_hv = 1'b0;
          state_nxt = S_DONE;
          if (is_prog(req_r.cmd)) begin
            // erased ones can only be cleared, so compare exactly
            if (din_s2_r == req_r.data) begin
              if (req_r.cmd == UPC_CMD_PROG_FAST) begin
                // final pulse gets its own settle time first
                final_nxt = 1'b1;
                cnt_nxt = 32'(SETUP_CYCLES);
                pins_nxt.prog_hv = 1'b1;
                pins_nxt.data_oe_n = 1'b0;
                state_nxt = S_SETUP;
              end
            end else if ((req_r.cmd == UPC_CMD_PROG_SHORT &&
                          x_r >= SHORT_MAX_PULSES) ||
                         (req_r.cmd == UPC_CMD_PROG_FAST &&
                          x_r >= FAST_MAX_PULSES)) begin
              rsp_nxt.fail = 1'b1;
            end else begin
              pins_nxt.prog_hv = 1'b1;
              pins_nxt.data_oe_n = 1'b0;
              cnt_nxt = 32'(SETUP_CYCLES);
              state_nxt = S_SETUP;
            end
          end
        end else begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      S_FINAL: begin
        if (cnt_r <= 32'd1) begin
          pins_nxt.chip_sel_n = 1'b1;
          cnt_nxt = 32'(SETUP_CYCLES);
          state_nxt = S_REL;
        end else begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      S_DONE: begin
        pins_nxt.data_oe_n = 1'b1;
        pins_nxt.prog_hv = 1'b0;
        pins_nxt.out_en_n = 1'b1;
        pins_nxt.chip_sel_n = 1'b1;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      req_r <= '0;
      rsp_r <= '0;
      cnt_r <= 32'h0000_0000;
      x_r <= 5'h00;
      final_r <= 1'b0;
      pins_r <= '{address_inputs: 16'h0000, id_unlock_hv: 1'b0,
                  chip_sel_n: 1'b1, out_en_n: 1'b1, prog_hv: 1'b0,
                  data_out: 8'h00, data_oe_n: 1'b1};
    end else if (clk_en) begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      rsp_r <= rsp_nxt;
      cnt_r <= cnt_nxt;
      x_r <= x_nxt;
      final_r <= final_nxt;
      pins_r <= pins_nxt;
    end
  end
endmodule
`default_nettype wire

// *** upc_pkg.sv ***
// Summary of operation
// - either pin high floats data; host deselects others
// - enable at high voltage, settle, pulse select
// - short pulses 100 us, fail after ten
// - fast prime pulses 1 ms, at most 25
// - final pulse lasts three X milliseconds
// - read back the programmed location, compare, report
// - any address order; parallel devices allowed
// - other addresses low during identifier reads
package upc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 25;
  localparam int SHORT_PULSE_US = 100;
  localparam int PRIME_PULSE_US = 1000;
  localparam int SETUP_US = 2;
  localparam int SHORT_PULSE_CYC = SHORT_PULSE_US * CLK_MHZ;
  localparam int PRIME_PULSE_CYC = PRIME_PULSE_US * CLK_MHZ;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int READ_WAIT_CYC = 8;
  localparam logic [4:0] SHORT_MAX_PULSES = 5'h0a;
  localparam logic [4:0] FAST_MAX_PULSES = 5'h19;
  localparam logic [1:0] FINAL_MULT = 2'h3;
  localparam logic [ADDR_W-1:0] ID_UNLOCK_BIT = 16'h0200;
  localparam logic [ADDR_W-1:0] ID_BYTE_BIT = 16'h0001;

  typedef enum logic [2:0] {
    UPC_CMD_READ = 3'h1,
    UPC_CMD_PROG_SHORT = 3'h2,
    UPC_CMD_PROG_FAST = 3'h3,
    UPC_CMD_ID = 3'h4
  } upc_cmd_t;

  typedef struct packed {
    upc_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } upc_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic fail;
    logic [4:0] pulses;
    logic parity_ok;
  } upc_rsp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address_inputs;
    logic id_unlock_hv;
    logic chip_sel_n;
    logic out_en_n;
    logic prog_hv;
    logic [DATA_W-1:0] data_out;
    logic data_oe_n;
  } upc_pins_t;
endpackage

// *** upc_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module upc_ctrl_properties #(
  parameter int SHORT_PULSE_CYCLES = 1,
  parameter int PRIME_PULSE_CYCLES = 1,
  parameter int SETUP_CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire upc_pkg::upc_req_t req,
  input wire logic rsp_valid,
  input wire upc_pkg::upc_rsp_t rsp,
  input wire upc_pkg::upc_pins_t pins,
  input wire logic [upc_pkg::DATA_W-1:0] data_pins_in
);
  import upc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);
  logic tk;
  logic rd;
  logic pg;
  logic [31:0] pl;
  assign tk = clk_en && req_valid && req_ready;
  assign rd = tk && req.cmd == UPC_CMD_READ;
  assign pg = pins.prog_hv && !pins.chip_sel_n;
  // length of the current program pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pl <= 32'h0000_0000;
    end else if (clk_en) begin
      pl <= pg ? pl + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  pulse_len_a: assert property ($fell(pg) |->
    (pl == 32'(SHORT_PULSE_CYCLES) || pl == 32'(PRIME_PULSE_CYCLES) ||
     pl == 32'(PRIME_PULSE_CYCLES) * 32'(FINAL_MULT) * 32'(rsp.pulses)))
    else $error("pulse length wrong");
  busy_after_take_a: assert property (tk |=> !req_ready)
    else $error("ready after take");
  done_not_ready_a: assert property (rsp_valid |-> !req_ready)
    else $error("ready while done");
  read_latency_a: assert property (rd |-> ##9 rsp_valid)
    else $error("read answer late");
  read_select_a: assert property (
    rd |-> ##1 (!pins.chip_sel_n && !pins.out_en_n) [*7])
    else $error("read pins wrong");
  no_clash_a: assert property (
    !pins.out_en_n |-> pins.data_oe_n && !pins.prog_hv)
    else $error("bus clash");
  bus_release_a: assert property (!pins.data_oe_n |-> pins.prog_hv)
    else $error("data driven outside programming");
  pulse_setup_a: assert property ($fell(pins.chip_sel_n) &&
    pins.prog_hv |-> $past(pins.prog_hv, 2) &&
    $stable(pins.data_out) && $stable(pins.address_inputs))
    else $error("pulse before settle");
  pulse_hold_a: assert property (pg && $past(pg) |->
    $stable(pins.address_inputs) && $stable(pins.data_out))
    else $error("pins moved in pulse");
  id_address_a: assert property (
    pins.id_unlock_hv |-> (pins.address_inputs & 16'hfdfe) == 16'h0000)
    else $error("id address not low");
  pulse_cap_a: assert property (rsp_valid |-> rsp.pulses <= 5'h19)
    else $error("too many pulses");
  cover property (rd);
  cover property (tk && req.cmd == UPC_CMD_ID);
  cover property (rsp_valid && rsp.fail);
  cover property ($fell(pg) && pl > 32'(PRIME_PULSE_CYCLES));
endmodule
bind upc_ctrl upc_ctrl_properties #(
  .SHORT_PULSE_CYCLES(SHORT_PULSE_CYCLES),
  .PRIME_PULSE_CYCLES(PRIME_PULSE_CYCLES),
  .SETUP_CYCLES(SETUP_CYCLES)
) u_props (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
  .data_pins_in(data_pins_in));
`default_nettype wire

// *** upc_eprom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module upc_eprom_model #(
  parameter logic [7:0] MAKER_CODE = 8'h07, // arbitrary, odd parity
  parameter logic [7:0] PART_CODE = 8'h8c // arbitrary, odd parity
) (
  input wire upc_pkg::upc_pins_t pins,
  output logic [7:0] data_pins_in
);
  import upc_pkg::*;
  logic [7:0] mem [65536];
  logic [7:0] last;
  logic [7:0] need;
  logic rd;
  logic armed;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    last = 8'h00;
    armed = 1'b0;
  end
  // a pulse counts only if select fell with high voltage on
  always @(negedge pins.chip_sel_n) begin
    armed = pins.prog_hv && !pins.data_oe_n;
  end
  // one bit cleared per pulse, so retries really happen
  always @(posedge pins.chip_sel_n) begin
    if (armed && pins.prog_hv && !pins.data_oe_n) begin
      need = mem[pins.address_inputs] & ~pins.data_out;
      mem[pins.address_inputs] &= ~(need & (~need + 8'h01));
    end
  end
  assign rd = !pins.chip_sel_n && !pins.out_en_n && !pins.prog_hv;
  always @* begin
    if (!pins.data_oe_n) begin
      data_pins_in = pins.data_out;
    end else if (rd) begin
      if (pins.id_unlock_hv) begin
        data_pins_in = pins.address_inputs[0] ? PART_CODE : MAKER_CODE;
      end else begin
        data_pins_in = mem[pins.address_inputs];
      end
    end else begin
      data_pins_in = ~last;
    end
  end
  always @(data_pins_in) if (rd) last = data_pins_in;
endmodule
`default_nettype wire

// *** test_uv_eprom_mode_and_program_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_uv_eprom_mode_and_program_ctrl;
  import upc_pkg::*;
  logic clk, rst_n, clk_en, req_valid, req_ready, rsp_valid;
  upc_req_t req;
  upc_rsp_t rsp, got;
  upc_pins_t pins;
  logic [7:0] data_pins_in;
  int fails, n_tests;
  upc_ctrl #(.SHORT_PULSE_CYCLES(4), .PRIME_PULSE_CYCLES(8),
    .SETUP_CYCLES(2)) u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .data_pins_in(data_pins_in));
  upc_eprom_model u_mem (.pins(pins), .data_pins_in(data_pins_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic test_done;
    $display("%0d checks, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic run(upc_cmd_t c, logic [15:0] a, logic [7:0] d);
    int i;
    logic [7:0] idle;
    @(negedge clk);
    idle = {2'b00, req_ready, pins.chip_sel_n, pins.out_en_n,
      pins.data_oe_n, pins.prog_hv, pins.id_unlock_hv};
    chk(idle, 8'h3c);
    req = '{c, a, d};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 4000 && rsp_valid !== 1'b1; i++) @(negedge clk);
    if (i == 4000) begin
      fails++;
      test_done;
    end
    got = rsp;
  endtask
  function automatic logic [7:0] st();
    return {2'b00, got.fail, got.pulses};
  endfunction
  task automatic test_read;
    run(UPC_CMD_READ, 16'hffff, 8'h00);
    chk(got.data, 8'hff);
    run(UPC_CMD_READ, 16'h0000, 8'h00);
    chk(got.data, 8'hff);
    $display("read test done");
  endtask
  task automatic test_short;
    run(UPC_CMD_PROG_SHORT, 16'h1234, 8'h5a);
    chk(st(), 8'h04);
    run(UPC_CMD_READ, 16'h1234, 8'h00);
    chk(got.data, 8'h5a);
    run(UPC_CMD_PROG_SHORT, 16'h1234, 8'hff);
    chk(st(), 8'h2a);
    $display("short test done");
  endtask
  task automatic test_fast;
    run(UPC_CMD_PROG_FAST, 16'h0002, 8'h7e);
    chk(st(), 8'h02);
    run(UPC_CMD_PROG_FAST, 16'h0002, 8'hff);
    chk(st(), 8'h39);
    run(UPC_CMD_READ, 16'h0002, 8'h00);
    chk(got.data, 8'h7e);
    $display("fast test done");
  endtask
  task automatic test_id;
    run(UPC_CMD_ID, 16'hfffe, 8'h00);
    chk(got.data, 8'h07);
    chk({7'h00, got.parity_ok}, 8'h01);
    run(UPC_CMD_ID, 16'h0001, 8'h00);
    chk(got.data, 8'h8c);
    $display("id test done");
  endtask
  task automatic test_freeze;
    int i;
    @(negedge clk);
    req = '{UPC_CMD_READ, 16'h1234, 8'h00};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    clk_en = 1'b0;
    repeat (20) @(negedge clk);
    chk({6'h00, rsp_valid, pins.chip_sel_n}, 8'h00);
    clk_en = 1'b1;
    for (i = 0; i < 40 && rsp_valid !== 1'b1; i++) @(negedge clk);
    if (i == 40) begin
      fails++;
      test_done;
    end
    chk(rsp.data, 8'h5a);
    $display("freeze test done");
  endtask
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req = '0;
    fails = 0;
    n_tests = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk({pins.chip_sel_n, pins.out_en_n, pins.data_oe_n}, 8'h07);
    test_read;
    test_short;
    test_fast;
    test_id;
    test_freeze;
    test_done;
  end
endmodule
`default_nettype wire
